// ---- mrca_pkg.sv ----
package mrca_pkg;

	// timing
	localparam int CLK_KHZ = 250000;
	localparam int TICK_MS = 100;
	localparam int TICK_CYCLES = TICK_MS * CLK_KHZ;

	// frame and status encodings
	localparam logic [7:0] FRAME_REMOTE_RESP = 8'h97;
	localparam logic [3:0] ST_OK = 4'h0;
	localparam logic [3:0] ST_ERROR = 4'h1;
	localparam logic [3:0] ST_BAD_CMD = 4'h2;
	localparam logic [3:0] ST_BAD_PARAM = 4'h3;
	localparam logic [3:0] ST_TX_FAIL = 4'h4;
	localparam logic [7:0] FLAG_STRENGTH_INVALID = 8'h40;
	localparam logic [7:0] FLAG_REMOTE = 8'h80;
	localparam logic [63:0] ADDR_INVALID = 64'h0000_0000_0000_FFFE;

	// reset values; serial rate code is arbitrary
	localparam logic [31:0] SERIAL_RATE_RST = 32'h0000_0003;
	localparam logic [31:0] DEST_HIGH_RST = 32'h0000_0000;
	localparam logic [31:0] DEST_LOW_RST = 32'h0000_FFFF;
	localparam logic [7:0] MAX_WAIT_RST = 8'h82;

	// random source and pwm counter width
	localparam int LFSR_W = 16;
	localparam logic [15:0] LFSR_SEED = 16'hACE1;
	localparam logic [15:0] LFSR_TAPS = 16'hB400;
	localparam int PWM_W = 8;

	typedef enum logic [3:0] {
		CMD_SERIAL_RATE_PARAM,
		CMD_DEST_HIGH_WORD,
		CMD_DEST_LOW_WORD,
		CMD_STRENGTH_PWM_ENABLE,
		CMD_DISCOVERY_MAX_WAIT,
		CMD_LAST_STRENGTH_QUERY,
		CMD_COMMIT_PENDING,
		CMD_SAVE,
		CMD_SOFT_RESTART,
		CMD_UNSUPPORTED
	} mrca_cmd_t;

	typedef struct packed {
		logic [31:0] serial_rate;
		logic [31:0] dest_high_word;
		logic [31:0] dest_low_word;
		logic strength_pwm_enable;
		logic [7:0] discovery_max_wait;
	} mrca_params_t;

	localparam mrca_params_t PARAMS_RST = '{
		serial_rate: SERIAL_RATE_RST,
		dest_high_word: DEST_HIGH_RST,
		dest_low_word: DEST_LOW_RST,
		strength_pwm_enable: 1'b0,
		discovery_max_wait: MAX_WAIT_RST
	};

endpackage : mrca_pkg

// ---- mrca_disc_if.sv ----
`timescale 1ns/1ps
interface mrca_disc_if;
	logic start;
	logic [7:0] window;
	logic done;
	logic busy;
	modport ctrl (output start, output window, input done, input busy);
	modport timer (input start, input window, output done, output busy);
endinterface : mrca_disc_if

// ---- mrca_disc_timer.sv ----
`timescale 1ns/1ps
module mrca_disc_timer #(
	parameter int TICK_CYCLES = mrca_pkg::TICK_CYCLES
) (
	// clock, reset, enable
	input wire logic clk,
	input wire logic reset,
	input wire logic ce,
	// request from the agent
	mrca_disc_if.timer tmr
);
	import mrca_pkg::*;

	localparam int TW = $clog2(TICK_CYCLES + 1);
	localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);

	typedef enum logic {T_IDLE, T_WAIT} mrca_tstate_t;

	typedef struct packed {
		mrca_tstate_t state;
		logic [LFSR_W-1:0] lfsr;
		logic [TW-1:0] tick_cnt;
		logic [7:0] ticks_left;
		logic done;
	} mrca_tmr_t;

	mrca_tmr_t s;
	mrca_tmr_t next_s;
	logic [15:0] scaled;

	always_comb
	begin
		next_s = s;
		next_s.done = 1'b0;
		// lfsr runs free so reply slots differ between nodes
		next_s.lfsr = {s.lfsr[LFSR_W-2:0], ^(s.lfsr & LFSR_TAPS)};
		// scaling instead of modulo: slot lands below the window
		scaled = 16'(s.lfsr[7:0]) * 16'(tmr.window);
		case (s.state)
		T_IDLE:
			next_s.tick_cnt = '0;
		T_WAIT:
			if (s.tick_cnt == TICK_LAST)
			begin
				next_s.tick_cnt = '0;
				if (s.ticks_left == '0)
				begin
					next_s.done = 1'b1;
					next_s.state = T_IDLE;
				end
				else
					next_s.ticks_left = s.ticks_left - 8'h01;
			end
			else
				next_s.tick_cnt = s.tick_cnt + TW'(1);
		default:
			next_s.state = T_IDLE;
		endcase
		// a fresh broadcast restarts the wait
		if (tmr.start)
		begin
			next_s.state = T_WAIT;
			next_s.tick_cnt = '0;
			next_s.ticks_left = scaled[15:8];
		end
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			s <= '{state: T_IDLE, lfsr: LFSR_SEED, tick_cnt: '0,
				ticks_left: 8'h00, done: 1'b0};
		else if (ce)
			s <= next_s;
	end

	assign tmr.done = s.done;
	assign tmr.busy = (s.state == T_WAIT);

	a_slot_in_window: assert property (
		@(posedge clk) disable iff (reset)
		(ce && tmr.start) |=> (s.ticks_left < $past(tmr.window)
			|| s.ticks_left == 8'h00))
		else $error("reply slot outside window");

	a_done_on_tick: assert property (
		@(posedge clk) disable iff (reset)
		$rose(s.done) |-> ($past(s.tick_cnt) == TICK_LAST
			&& $past(s.ticks_left) == 8'h00))
		else $error("reply not on a tick boundary");

	a_done_after_wait: assert property (
		@(posedge clk) disable iff (reset)
		$rose(s.done) |-> $past(tmr.busy))
		else $error("reply without a running wait");

endmodule : mrca_disc_timer

// ---- mrca_agent.sv ----
`timescale 1ns/1ps
module mrca_agent #(
	parameter int TICK_CYCLES = mrca_pkg::TICK_CYCLES
) (
	// clock, reset, enable
	input wire logic clk,
	input wire logic reset,
	input wire logic ce,
	// identity and mode
	input wire logic [63:0] own_addr,
	input wire logic [63:0] node_label_string,
	input wire logic host_frame_mode,
	// remote request arriving at this node
	input wire logic rx_req_valid,
	input wire logic [7:0] rx_req_frame_id,
	input wire logic rx_req_apply,
	input wire mrca_pkg::mrca_cmd_t rx_req_cmd,
	input wire logic rx_req_has_param,
	input wire logic [31:0] rx_req_param,
	input wire logic [63:0] rx_req_src,
	// response transmission to requester
	output logic resp_tx_valid,
	output logic [63:0] resp_tx_dest,
	output logic [7:0] resp_tx_frame_id,
	output mrca_pkg::mrca_cmd_t resp_tx_cmd,
	output logic [7:0] resp_tx_status,
	output logic [31:0] resp_tx_data,
	// remote response arriving from a target
	input wire logic rx_resp_valid,
	input wire logic [7:0] rx_resp_frame_id,
	input wire logic [63:0] rx_resp_src,
	input wire mrca_pkg::mrca_cmd_t rx_resp_cmd,
	input wire logic [7:0] rx_resp_status,
	input wire logic [31:0] rx_resp_data,
	// response frame to host
	output logic host_resp_valid,
	output logic [7:0] host_resp_type,
	output logic [7:0] host_resp_frame_id,
	output logic [63:0] host_resp_src,
	output mrca_pkg::mrca_cmd_t host_resp_cmd,
	output logic [7:0] host_resp_status,
	output logic [31:0] host_resp_data,
	// active settings
	output logic [31:0] serial_rate_param,
	output logic [63:0] unicast_dest,
	// collector broadcast
	input wire logic rx_agg_valid,
	input wire logic [63:0] rx_agg_param,
	input wire logic [63:0] rx_agg_src,
	output logic agg_update_valid,
	output logic [63:0] agg_update_addr,
	output logic route_update_valid,
	output logic [63:0] route_update_addr,
	// signal strength
	input wire logic rx_pkt_valid,
	input wire logic [7:0] rx_pkt_strength,
	output logic strength_pwm,
	// discovery
	input wire logic host_disc_req,
	output logic disc_bcast_valid,
	output logic [7:0] disc_bcast_window,
	input wire logic rx_disc_valid,
	input wire logic [7:0] rx_disc_window,
	input wire logic [63:0] rx_disc_src,
	output logic disc_reply_valid,
	output logic [63:0] disc_reply_dest,
	output logic [63:0] disc_reply_addr,
	output logic [63:0] disc_reply_label
);
	import mrca_pkg::*;

	typedef struct packed {
		mrca_params_t pend;
		mrca_params_t act;
		logic saved;
		logic [7:0] last_str;
		logic str_seen;
		logic [PWM_W-1:0] pwm_cnt;
		logic [PWM_W-1:0] duty;
		logic pwm_out;
		logic resp_tx_valid;
		logic [63:0] resp_tx_dest;
		logic [7:0] resp_tx_frame_id;
		mrca_cmd_t resp_tx_cmd;
		logic [7:0] resp_tx_status;
		logic [31:0] resp_tx_data;
		logic host_resp_valid;
		logic [7:0] host_resp_frame_id;
		logic [63:0] host_resp_src;
		mrca_cmd_t host_resp_cmd;
		logic [7:0] host_resp_status;
		logic [31:0] host_resp_data;
		logic agg_update_valid;
		logic route_update_valid;
		logic [63:0] route_update_addr;
		logic disc_bcast_valid;
		logic [7:0] disc_bcast_window;
		logic disc_start;
		logic [7:0] disc_window;
		logic [63:0] disc_dest;
		logic disc_reply_valid;
		logic [63:0] disc_reply_dest;
		logic [63:0] disc_reply_addr;
		logic [63:0] disc_reply_label;
	} mrca_state_t;

	mrca_state_t s;
	mrca_state_t next_s;
	logic [3:0] req_result;
	logic [7:0] req_flags;
	logic [31:0] req_data;
	logic req_commit;

	mrca_disc_if disc ();

	function automatic logic [63:0] dest_of(input mrca_params_t p);
		dest_of = {p.dest_high_word, p.dest_low_word};
	endfunction : dest_of

	function automatic logic [7:0] status_byte(input logic [3:0] result,
		input logic [7:0] flags);
		status_byte = {flags[7:4], result};
	endfunction : status_byte

	function automatic logic [31:0] param_read(input mrca_params_t p,
		input mrca_cmd_t c);
		case (c)
		CMD_SERIAL_RATE_PARAM: param_read = p.serial_rate;
		CMD_DEST_HIGH_WORD: param_read = p.dest_high_word;
		CMD_DEST_LOW_WORD: param_read = p.dest_low_word;
		CMD_STRENGTH_PWM_ENABLE:
			param_read = {31'h0000_0000, p.strength_pwm_enable};
		CMD_DISCOVERY_MAX_WAIT:
			param_read = {24'h00_0000, p.discovery_max_wait};
		default: param_read = 32'h0000_0000;
		endcase
	endfunction : param_read

	function automatic mrca_params_t param_write(input mrca_params_t p,
		input mrca_cmd_t c, input logic [31:0] v);
		param_write = p;
		case (c)
		CMD_SERIAL_RATE_PARAM: param_write.serial_rate = v;
		CMD_DEST_HIGH_WORD: param_write.dest_high_word = v;
		CMD_DEST_LOW_WORD: param_write.dest_low_word = v;
		CMD_STRENGTH_PWM_ENABLE: param_write.strength_pwm_enable = v[0];
		CMD_DISCOVERY_MAX_WAIT: param_write.discovery_max_wait = v[7:0];
		default: param_write = p;
		endcase
	endfunction : param_write

	always_comb
	begin
		next_s = s;
		req_result = ST_OK;
		req_flags = 8'h00;
		req_data = 32'h0000_0000;
		req_commit = 1'b0;
		next_s.resp_tx_valid = 1'b0;
		next_s.host_resp_valid = 1'b0;
		next_s.agg_update_valid = 1'b0;
		next_s.route_update_valid = 1'b0;
		next_s.disc_bcast_valid = 1'b0;
		next_s.disc_start = 1'b0;
		next_s.disc_reply_valid = 1'b0;

		// strength capture and pwm
		next_s.pwm_cnt = s.pwm_cnt + PWM_W'(1);
		next_s.pwm_out = s.act.strength_pwm_enable && (s.pwm_cnt < s.duty);
		if (rx_pkt_valid)
		begin
			next_s.last_str = rx_pkt_strength;
			next_s.str_seen = 1'b1;
			// smaller magnitude is a stronger link, so wider pulse
			if (s.act.strength_pwm_enable)
				next_s.duty = ~rx_pkt_strength;
		end

		// remote request at this node
		if (rx_req_valid)
		begin
			req_commit = rx_req_apply;
			case (rx_req_cmd)
			CMD_SERIAL_RATE_PARAM, CMD_DEST_HIGH_WORD, CMD_DEST_LOW_WORD,
			CMD_STRENGTH_PWM_ENABLE, CMD_DISCOVERY_MAX_WAIT:
				if (rx_req_has_param)
					next_s.pend = param_write(s.pend, rx_req_cmd,
						rx_req_param);
				else
					req_data = param_read(s.pend, rx_req_cmd);
			CMD_LAST_STRENGTH_QUERY:
				if (rx_req_has_param)
					req_result = ST_BAD_PARAM;
				else
				begin
					req_data = {24'h00_0000, s.last_str};
					if (!s.str_seen)
						req_flags = FLAG_STRENGTH_INVALID;
				end
			CMD_COMMIT_PENDING:
				req_commit = 1'b1;
			CMD_SAVE:
				next_s.saved = 1'b1;
			CMD_SOFT_RESTART:
			begin
				// restart without a save drops what is pending
				if (s.saved)
					req_commit = 1'b1;
				else
					next_s.pend = s.act;
				next_s.saved = 1'b0;
			end
			default:
				req_result = ST_BAD_CMD;
			endcase
			if (req_commit)
				next_s.act = next_s.pend;
			if (rx_req_frame_id != 8'h00)
			begin
				next_s.resp_tx_valid = 1'b1;
				next_s.resp_tx_dest = rx_req_src;
				next_s.resp_tx_frame_id = rx_req_frame_id;
				next_s.resp_tx_cmd = rx_req_cmd;
				next_s.resp_tx_status = status_byte(req_result, req_flags);
				next_s.resp_tx_data = req_data;
			end
		end

		// only an arriving answer makes a host frame
		if (rx_resp_valid)
		begin
			next_s.host_resp_valid = 1'b1;
			next_s.host_resp_frame_id = rx_resp_frame_id;
			next_s.host_resp_src = rx_resp_src;
			next_s.host_resp_cmd = rx_resp_cmd;
			next_s.host_resp_status = status_byte(rx_resp_status[3:0],
				rx_resp_status | FLAG_REMOTE);
			next_s.host_resp_data = rx_resp_data;
		end

		// collector broadcast; compared with the settings in force
		if (rx_agg_valid)
		begin
			next_s.route_update_valid = 1'b1;
			next_s.route_update_addr = rx_agg_src;
			if (rx_agg_param != ADDR_INVALID
				&& rx_agg_param == dest_of(s.act))
			begin
				{next_s.act.dest_high_word,
					next_s.act.dest_low_word} = rx_agg_src;
				{next_s.pend.dest_high_word,
					next_s.pend.dest_low_word} = rx_agg_src;
				next_s.agg_update_valid = host_frame_mode;
			end
		end

		// discovery
		if (host_disc_req)
		begin
			next_s.disc_bcast_valid = 1'b1;
			next_s.disc_bcast_window = s.act.discovery_max_wait;
		end
		if (disc.done)
		begin
			next_s.disc_reply_valid = 1'b1;
			next_s.disc_reply_dest = s.disc_dest;
			next_s.disc_reply_addr = own_addr;
			next_s.disc_reply_label = node_label_string;
		end
		if (rx_disc_valid)
		begin
			next_s.disc_start = 1'b1;
			next_s.disc_window = rx_disc_window;
			next_s.disc_dest = rx_disc_src;
		end
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			s <= '{pend: PARAMS_RST, act: PARAMS_RST,
				resp_tx_cmd: CMD_UNSUPPORTED,
				host_resp_cmd: CMD_UNSUPPORTED, default: '0};
		else if (ce)
			s <= next_s;
	end

	assign disc.start = s.disc_start;
	assign disc.window = s.disc_window;

	mrca_disc_timer #(
		.TICK_CYCLES(TICK_CYCLES)
	) u_timer (
		.clk(clk),
		.reset(reset),
		.ce(ce),
		.tmr(disc.timer)
	);

	assign resp_tx_valid = s.resp_tx_valid;
	assign resp_tx_dest = s.resp_tx_dest;
	assign resp_tx_frame_id = s.resp_tx_frame_id;
	assign resp_tx_cmd = s.resp_tx_cmd;
	assign resp_tx_status = s.resp_tx_status;
	assign resp_tx_data = s.resp_tx_data;
	assign host_resp_valid = s.host_resp_valid;
	assign host_resp_type = FRAME_REMOTE_RESP;
	assign host_resp_frame_id = s.host_resp_frame_id;
	assign host_resp_src = s.host_resp_src;
	assign host_resp_cmd = s.host_resp_cmd;
	assign host_resp_status = s.host_resp_status;
	assign host_resp_data = s.host_resp_data;
	assign serial_rate_param = s.act.serial_rate;
	assign unicast_dest = dest_of(s.act);
	assign agg_update_valid = s.agg_update_valid;
	assign agg_update_addr = dest_of(s.act);
	assign route_update_valid = s.route_update_valid;
	assign route_update_addr = s.route_update_addr;
	assign strength_pwm = s.pwm_out;
	assign disc_bcast_valid = s.disc_bcast_valid;
	assign disc_bcast_window = s.disc_bcast_window;
	assign disc_reply_valid = s.disc_reply_valid;
	assign disc_reply_dest = s.disc_reply_dest;
	assign disc_reply_addr = s.disc_reply_addr;
	assign disc_reply_label = s.disc_reply_label;

	a_zero_id_silent: assert property (
		@(posedge clk) disable iff (reset)
		(ce && rx_req_valid && rx_req_frame_id == 8'h00) |=> !resp_tx_valid)
		else $error("response sent for zero frame id");

	a_id_echoed: assert property (
		@(posedge clk) disable iff (reset)
		(ce && rx_req_valid && rx_req_frame_id != 8'h00)
		|=> (resp_tx_valid && resp_tx_frame_id == $past(rx_req_frame_id)
			&& resp_tx_dest == $past(rx_req_src)))
		else $error("response missing or id not echoed");

	a_pending_held: assert property (
		@(posedge clk) disable iff (reset)
		(ce && rx_req_valid && rx_req_has_param && !rx_req_apply
			&& rx_req_cmd == CMD_SERIAL_RATE_PARAM)
		|=> $stable(serial_rate_param))
		else $error("pending write changed active rate");

	a_apply_bit: assert property (
		@(posedge clk) disable iff (reset)
		(ce && rx_req_valid && rx_req_has_param && rx_req_apply
			&& rx_req_cmd == CMD_SERIAL_RATE_PARAM)
		|=> serial_rate_param == $past(rx_req_param))
		else $error("apply bit did not commit");

	a_resp_frame: assert property (
		@(posedge clk) disable iff (reset)
		(ce && rx_resp_valid) |=> (host_resp_valid
			&& host_resp_status[7] && host_resp_type == FRAME_REMOTE_RESP
			&& host_resp_data == $past(rx_resp_data)))
		else $error("remote answer not forwarded");

	a_no_answer: assert property (
		@(posedge clk) disable iff (reset)
		(ce && !rx_resp_valid) |=> !host_resp_valid)
		else $error("host frame without answer");

	a_agg_rewrite: assert property (
		@(posedge clk) disable iff (reset)
		(ce && rx_agg_valid && !rx_req_valid && rx_agg_param == unicast_dest
			&& rx_agg_param != ADDR_INVALID)
		|=> (unicast_dest == $past(rx_agg_src)
			&& agg_update_valid == $past(host_frame_mode)))
		else $error("collector rewrite wrong");

	a_agg_invalid: assert property (
		@(posedge clk) disable iff (reset)
		(ce && rx_agg_valid && !rx_req_valid && rx_agg_param == ADDR_INVALID)
		|=> ($stable(unicast_dest) && !agg_update_valid))
		else $error("invalid address changed destination");

	a_route_always: assert property (
		@(posedge clk) disable iff (reset)
		(ce && rx_agg_valid) |=> (route_update_valid
			&& route_update_addr == $past(rx_agg_src)))
		else $error("route not installed");

	a_bcast_window: assert property (
		@(posedge clk) disable iff (reset)
		(ce && host_disc_req) |=> (disc_bcast_valid
			&& disc_bcast_window == $past(s.act.discovery_max_wait)))
		else $error("broadcast window not own setting");

	a_wait_reset: assert property (
		@(posedge clk)
		$fell(reset) |-> s.act.discovery_max_wait == 8'h82)
		else $error("maximum wait reset value wrong");

endmodule : mrca_agent

// ---- mrca_peer.sv ----
`timescale 1ns/1ps
module mrca_peer (
	// clock
	input wire logic clk,
	// request arriving at the node
	output logic rx_req_valid,
	output logic [7:0] rx_req_frame_id,
	output logic rx_req_apply,
	output mrca_pkg::mrca_cmd_t rx_req_cmd,
	output logic rx_req_has_param,
	output logic [31:0] rx_req_param,
	output logic [63:0] rx_req_src,
	// answer from a target
	output logic rx_resp_valid,
	output logic [7:0] rx_resp_frame_id,
	output logic [63:0] rx_resp_src,
	output mrca_pkg::mrca_cmd_t rx_resp_cmd,
	output logic [7:0] rx_resp_status,
	output logic [31:0] rx_resp_data,
	// broadcasts and packets
	output logic rx_agg_valid,
	output logic [63:0] rx_agg_param,
	output logic [63:0] rx_agg_src,
	output logic rx_pkt_valid,
	output logic [7:0] rx_pkt_strength,
	output logic rx_disc_valid,
	output logic [7:0] rx_disc_window,
	output logic [63:0] rx_disc_src
);
	import mrca_pkg::*;

	initial
	begin
		rx_req_cmd = CMD_UNSUPPORTED;
		rx_resp_cmd = CMD_UNSUPPORTED;
		{rx_req_valid, rx_req_frame_id, rx_req_apply} = '0;
		{rx_req_has_param, rx_req_param, rx_req_src} = '0;
		{rx_resp_valid, rx_resp_frame_id, rx_resp_src} = '0;
		{rx_resp_status, rx_resp_data, rx_agg_valid} = '0;
		{rx_agg_param, rx_agg_src, rx_pkt_valid, rx_pkt_strength} = '0;
		{rx_disc_valid, rx_disc_window, rx_disc_src} = '0;
	end

	// a peer sends only whole pulses; released data is inverted, not held
	task automatic req(input logic [7:0] id, input mrca_cmd_t c,
		input logic a, input logic hp, input logic [31:0] v);
		@(posedge clk);
		rx_req_frame_id <= id;
		rx_req_cmd <= c;
		rx_req_apply <= a;
		rx_req_has_param <= hp;
		rx_req_param <= v;
		rx_req_src <= {$urandom, $urandom};
		rx_req_valid <= 1'b1;
		@(posedge clk);
		rx_req_valid <= 1'b0;
		rx_req_param <= ~v;
	endtask : req

	task automatic resp(input logic [7:0] id, input logic [7:0] st,
		input logic [31:0] d, input logic [63:0] src);
		@(posedge clk);
		rx_resp_frame_id <= id;
		rx_resp_status <= st;
		rx_resp_data <= d;
		rx_resp_src <= src;
		rx_resp_cmd <= CMD_LAST_STRENGTH_QUERY;
		rx_resp_valid <= 1'b1;
		@(posedge clk);
		rx_resp_valid <= 1'b0;
		rx_resp_data <= ~d;
	endtask : resp

	task automatic agg(input logic [63:0] prm, input logic [63:0] src);
		@(posedge clk);
		rx_agg_param <= prm;
		rx_agg_src <= src;
		rx_agg_valid <= 1'b1;
		@(posedge clk);
		rx_agg_valid <= 1'b0;
		rx_agg_param <= ~prm;
	endtask : agg

	task automatic pkt(input logic [7:0] s);
		@(posedge clk);
		rx_pkt_strength <= s;
		rx_pkt_valid <= 1'b1;
		@(posedge clk);
		rx_pkt_valid <= 1'b0;
		rx_pkt_strength <= ~s;
	endtask : pkt

	task automatic disc(input logic [7:0] w, input logic [63:0] src);
		@(posedge clk);
		rx_disc_window <= w;
		rx_disc_src <= src;
		rx_disc_valid <= 1'b1;
		@(posedge clk);
		rx_disc_valid <= 1'b0;
		rx_disc_window <= ~w;
	endtask : disc
endmodule : mrca_peer

// ---- mrca_agent_tb.sv ----
`timescale 1ns/1ps
module mrca_agent_tb;
	import mrca_pkg::*;
	localparam int TK = 4;
	logic clk, reset, ce, host_frame_mode, host_disc_req;
	logic [63:0] own_addr, node_label_string;
	logic rx_req_valid, rx_req_apply, rx_req_has_param;
	logic [7:0] rx_req_frame_id, rx_resp_frame_id, rx_resp_status;
	logic [31:0] rx_req_param, rx_resp_data, resp_tx_data;
	logic [63:0] rx_req_src, rx_resp_src, resp_tx_dest, host_resp_src;
	mrca_cmd_t rx_req_cmd, rx_resp_cmd, resp_tx_cmd, host_resp_cmd;
	logic rx_resp_valid, resp_tx_valid, host_resp_valid;
	logic [7:0] resp_tx_frame_id, resp_tx_status, host_resp_type;
	logic [7:0] host_resp_frame_id, host_resp_status, rx_pkt_strength;
	logic [7:0] disc_bcast_window, rx_disc_window;
	logic [31:0] host_resp_data, serial_rate_param;
	logic [63:0] unicast_dest, rx_agg_param, rx_agg_src;
	logic rx_agg_valid, agg_update_valid, route_update_valid, rx_pkt_valid;
	logic [63:0] agg_update_addr, route_update_addr, rx_disc_src;
	logic strength_pwm, disc_bcast_valid, rx_disc_valid, disc_reply_valid;
	logic [63:0] disc_reply_dest, disc_reply_addr, disc_reply_label;
	int error_cnt = 0;
	int n_tests = 0;

	mrca_peer p (.clk, .rx_req_valid, .rx_req_frame_id, .rx_req_apply,
		.rx_req_cmd, .rx_req_has_param, .rx_req_param, .rx_req_src,
		.rx_resp_valid, .rx_resp_frame_id, .rx_resp_src, .rx_resp_cmd,
		.rx_resp_status, .rx_resp_data, .rx_agg_valid, .rx_agg_param,
		.rx_agg_src, .rx_pkt_valid, .rx_pkt_strength, .rx_disc_valid,
		.rx_disc_window, .rx_disc_src);

	mrca_agent #(.TICK_CYCLES(TK)) dut (.clk, .reset, .ce, .own_addr,
		.node_label_string, .host_frame_mode, .rx_req_valid,
		.rx_req_frame_id, .rx_req_apply, .rx_req_cmd, .rx_req_has_param,
		.rx_req_param, .rx_req_src, .resp_tx_valid, .resp_tx_dest,
		.resp_tx_frame_id, .resp_tx_cmd, .resp_tx_status, .resp_tx_data,
		.rx_resp_valid, .rx_resp_frame_id, .rx_resp_src, .rx_resp_cmd,
		.rx_resp_status, .rx_resp_data, .host_resp_valid, .host_resp_type,
		.host_resp_frame_id, .host_resp_src, .host_resp_cmd,
		.host_resp_status, .host_resp_data, .serial_rate_param,
		.unicast_dest, .rx_agg_valid, .rx_agg_param, .rx_agg_src,
		.agg_update_valid, .agg_update_addr, .route_update_valid,
		.route_update_addr, .rx_pkt_valid, .rx_pkt_strength, .strength_pwm,
		.host_disc_req, .disc_bcast_valid, .disc_bcast_window,
		.rx_disc_valid, .rx_disc_window, .rx_disc_src, .disc_reply_valid,
		.disc_reply_dest, .disc_reply_addr, .disc_reply_label);

	function automatic logic [63:0] remote_st(input logic [7:0] st);
		return {56'h0, st | FLAG_REMOTE};
	endfunction : remote_st

	function automatic logic [63:0] duty_of(input logic [7:0] m);
		return {56'h0, ~m};
	endfunction : duty_of

	task automatic chk(input string n, input logic [63:0] e,
		input logic [63:0] g);
		n_tests++;
		if (g !== e)
		begin
			error_cnt++;
			$display("[FAIL] %s exp %h got %h", n, e, g);
		end
	endtask : chk

	task automatic chkb(input string n, input logic e, input logic g);
		chk(n, {63'h0, e}, {63'h0, g});
	endtask : chkb

	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : end_of_test

	task automatic cmd(input logic [7:0] id, input mrca_cmd_t c,
		input logic a, input logic hp, input logic [31:0] v);
		p.req(id, c, a, hp, v);
		#1;
		chkb("resp_valid", id != 8'h00, resp_tx_valid);
		if (id != 8'h00)
		begin
			chk("resp_id", {56'h0, id}, {56'h0, resp_tx_frame_id});
			chk("resp_cmd", 64'(c), 64'(resp_tx_cmd));
		end
	endtask : cmd

	task automatic bcast(input logic [7:0] e);
		@(posedge clk);
		host_disc_req <= 1'b1;
		@(posedge clk);
		host_disc_req <= 1'b0;
		#1;
		chkb("bcast_valid", 1'b1, disc_bcast_valid);
		chk("bcast_win", {56'h0, e}, {56'h0, disc_bcast_window});
	endtask : bcast

	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	initial
	begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		end_of_test();
	end

	initial
	begin
		logic [31:0] v, v2, v3;
		logic [63:0] s;
		logic [7:0] st;
		int h, n, w;
		v = $urandom(32'hA4417412);
		{reset, ce, host_frame_mode, host_disc_req} = 4'hC;
		own_addr = {$urandom, $urandom};
		node_label_string = {$urandom, $urandom};
		repeat (12) @(posedge clk);
		reset <= 1'b0;
		#1;
		chk("dest_rst", {DEST_HIGH_RST, DEST_LOW_RST}, unicast_dest);
		bcast(8'h82);
		v = $urandom;
		v2 = $urandom;
		v3 = $urandom;
		cmd(8'h11, CMD_SERIAL_RATE_PARAM, 1'b0, 1'b1, v);
		chk("rate", SERIAL_RATE_RST, serial_rate_param);
		cmd(8'h12, CMD_SERIAL_RATE_PARAM, 1'b0, 1'b0, 32'h0);
		chk("query", v, resp_tx_data);
		chk("rate", SERIAL_RATE_RST, serial_rate_param);
		cmd(8'h13, CMD_COMMIT_PENDING, 1'b0, 1'b0, 32'h0);
		chk("rate", v, serial_rate_param);
		cmd(8'hFF, CMD_SERIAL_RATE_PARAM, 1'b1, 1'b1, v2);
		chk("rate", v2, serial_rate_param);
		cmd(8'h14, CMD_SERIAL_RATE_PARAM, 1'b0, 1'b1, v3);
		cmd(8'h15, CMD_SAVE, 1'b0, 1'b0, 32'h0);
		chk("rate", v2, serial_rate_param);
		cmd(8'h16, CMD_SOFT_RESTART, 1'b0, 1'b0, 32'h0);
		chk("rate", v3, serial_rate_param);
		// restart without save throws the pending value away
		cmd(8'h17, CMD_SERIAL_RATE_PARAM, 1'b0, 1'b1, v);
		cmd(8'h18, CMD_SOFT_RESTART, 1'b0, 1'b0, 32'h0);
		cmd(8'h19, CMD_COMMIT_PENDING, 1'b0, 1'b0, 32'h0);
		chk("rate", v3, serial_rate_param);
		cmd(8'h00, CMD_SERIAL_RATE_PARAM, 1'b1, 1'b1, v2);
		chk("rate", v2, serial_rate_param);
		cmd(8'h20, CMD_UNSUPPORTED, 1'b0, 1'b0, 32'h0);
		chk("status", {60'h0, ST_BAD_CMD}, resp_tx_status);
		cmd(8'h21, CMD_LAST_STRENGTH_QUERY, 1'b0, 1'b0, 32'h0);
		chk("status", FLAG_STRENGTH_INVALID, resp_tx_status);
		cmd(8'h22, CMD_LAST_STRENGTH_QUERY, 1'b0, 1'b1, 32'h0);
		chk("status", {60'h0, ST_BAD_PARAM}, resp_tx_status);
		cmd(8'h23, CMD_DISCOVERY_MAX_WAIT, 1'b1, 1'b1, 32'h5);
		bcast(8'h05);
		// every status code passes through with the remote flag added
		for (int i = 0; i < 5; i++)
		begin
			st = 8'(i);
			v = $urandom;
			s = {$urandom, $urandom};
			p.resp(8'(i + 1), st, v, s);
			#1;
			chkb("host_valid", 1'b1, host_resp_valid);
			chk("host_type", FRAME_REMOTE_RESP, host_resp_type);
			chk("host_id", 64'(i + 1), host_resp_frame_id);
			chk("host_st", remote_st(st), host_resp_status);
			chk("host_data", v, host_resp_data);
			chk("host_src", s, host_resp_src);
			chk("host_cmd", CMD_LAST_STRENGTH_QUERY, host_resp_cmd);
		end
		// let the last forwarded pulse end before counting
		@(posedge clk);
		n = 0;
		repeat (16)
		begin
			@(negedge clk);
			n += int'(host_resp_valid === 1'b1);
		end
		chk("no_answer", 64'h0, 64'(n));
		// invalid-address parameter must not rewrite a matching dest
		cmd(8'h30, CMD_DEST_HIGH_WORD, 1'b1, 1'b1, ADDR_INVALID[63:32]);
		cmd(8'h31, CMD_DEST_LOW_WORD, 1'b1, 1'b1, ADDR_INVALID[31:0]);
		chk("dest", ADDR_INVALID, unicast_dest);
		s = {$urandom, $urandom};
		p.agg(ADDR_INVALID, s);
		#1;
		chk("dest", ADDR_INVALID, unicast_dest);
		chkb("agg_upd", 1'b0, agg_update_valid);
		chkb("route", 1'b1, route_update_valid);
		chk("route_addr", s, route_update_addr);
		// leave the invalid address, or no broadcast could ever match
		cmd(8'h32, CMD_DEST_HIGH_WORD, 1'b1, 1'b1, $urandom | 32'h1);
		for (int i = 0; i < 2; i++)
		begin
			@(posedge clk) host_frame_mode <= 1'(i);
			v = unicast_dest[31:0];
			s = {$urandom, $urandom};
			p.agg(unicast_dest, s);
			#1;
			chk("dest", s, unicast_dest);
			chkb("agg_upd", 1'(i), agg_update_valid);
			chkb("route", 1'b1, route_update_valid);
		end
		chk("agg_addr", s, agg_update_addr);
		p.agg({$urandom, $urandom}, own_addr);
		#1;
		chk("dest", s, unicast_dest);
		chkb("route", 1'b1, route_update_valid);
		cmd(8'h40, CMD_STRENGTH_PWM_ENABLE, 1'b1, 1'b1, 32'h1);
		for (int i = 0; i < 2; i++)
		begin
			st = (i == 0) ? 8'h00 : 8'($urandom_range(1, 254));
			p.pkt(st);
			cmd(8'h41, CMD_LAST_STRENGTH_QUERY, 1'b0, 1'b0, 32'h0);
			chk("strength", {56'h0, st}, {56'h0, resp_tx_data[7:0]});
			repeat (4) @(posedge clk);
			h = 0;
			repeat (256)
			begin
				@(negedge clk);
				h += int'(strength_pwm === 1'b1);
			end
			chk("pwm_high", duty_of(st), 64'(h));
		end
		for (int i = 0; i < 4; i++)
		begin
			w = (i == 0) ? 1 : $urandom_range(1, 5);
			s = {$urandom, $urandom};
			p.disc(8'(w), s);
			n = 0;
			while (disc_reply_valid !== 1'b1 && n < w * TK + 8)
			begin
				@(negedge clk);
				n++;
			end
			chkb("disc_min", 1'b1, n >= TK);
			chkb("disc_max", 1'b1, disc_reply_valid);
			chk("disc_dest", s, disc_reply_dest);
			chk("disc_addr", own_addr, disc_reply_addr);
			chk("disc_label", node_label_string, disc_reply_label);
		end
		end_of_test();
	end
endmodule : mrca_agent_tb
